// ===== rtl/dual_comparator_control.sv
// Control, status and change detection around two analog comparators.
// Assumes a register port on clk_sys and raw comparator levels that
// arrive asynchronously from the analog macro.
`timescale 1ns/100ps

module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  ce,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  cmp1_raw,
  input  wire logic                  cmp2_raw,
  input  wire logic [PORT_LINES-1:0] port_a_in,
  output logic      [1:0]            port_a_hi_out,
  output logic      [1:0]            port_a_hi_oe_b,
  output logic      [2:0]            cmp_mode_sel,
  output logic                       input_switch,
  output logic                       vref_to_plus,
  output logic                       cmp_power,
  output logic      [ANALOG_LINES-1:0] analog_select,
  input  wire logic                  halt,
  output logic                       irq_req,
  output logic                       wake_req
);

  // ==================================================================
  // Decoding helpers.

  // Lines 0 to 3 are analog in every mode except the off mode.
  function automatic logic [ANALOG_LINES-1:0] analog_of(
    input logic [2:0] mode
  );
    analog_of = (mode == MODE_OFF) ? '0 : '1;
  endfunction

  // Comparators run in every mode except reset and off.
  function automatic logic active_of(input logic [2:0] mode);
    active_of = (mode != MODE_OFF) && (mode != MODE_RESET);
  endfunction

  // ==================================================================
  // State.

  logic [5:0]            control;
  logic                  irq_flag;
  logic                  irq_enable;
  logic                  periph_enable;
  logic                  global_enable;
  logic [5:0]            port_data;
  logic [5:0]            port_dir;
  logic [1:0]            result_ref;

  logic [5:0]            next_control;
  logic                  next_irq_flag;
  logic [2:0]            next_irq_bits;
  logic [5:0]            next_port_data;
  logic [5:0]            next_port_dir;
  logic [1:0]            next_result_ref;
  logic [7:0]            next_rdata;

  // ==================================================================
  // Synchronised inputs.

  logic [1:0]            cmp_sync;
  logic [PORT_LINES-1:0] pin_sync;

  sync2 #(
    .WIDTH (2)
  ) u_cmp_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .d       ({cmp2_raw, cmp1_raw}),
    .q       (cmp_sync)
  );

  sync2 #(
    .WIDTH (PORT_LINES)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .d       (port_a_in),
    .q       (pin_sync)
  );

  // ==================================================================
  // Control fields.

  wire [2:0] mode      = control[MODE_MSB:0];
  wire [1:0] polarity  = {control[BIT_CMP2_POLARITY],
                          control[BIT_CMP1_POLARITY]};
  wire       in_switch = control[BIT_INPUT_SWITCH];
  wire       active    = active_of(mode);
  wire       route_out = (mode == MODE_OUT_PIN);

  // ==================================================================
  // Result path.

  // Comparators that are switched off report their polarity bit as the result.
  wire [1:0] cmp_gated = active ? cmp_sync : 2'h0;
  wire [1:0] result    = cmp_gated ^ polarity;

  // ==================================================================
  // Register decode.

  wire sel_cmp  = (reg_addr == OFS_CMP_CONTROL);
  wire sel_irq  = (reg_addr == OFS_IRQ_CONTROL);
  wire sel_dat  = (reg_addr == OFS_PORT_DATA);
  wire sel_dir  = (reg_addr == OFS_PORT_DIR);

  wire wr_cmp   = reg_wr && sel_cmp;
  wire wr_irq   = reg_wr && sel_irq;
  wire wr_dat   = reg_wr && sel_dat;
  wire wr_dir   = reg_wr && sel_dir;
  wire acc_cmp  = (reg_wr || reg_rd) && sel_cmp;

  // ==================================================================
  // Change detection.

  wire mismatch = (result != result_ref);

  // Any access to the control word takes the present results as the
  // new reference, which ends the mismatch on the next cycle unless a write changes polarity or switches the comparators on or off.
  assign next_result_ref = acc_cmp ? result : result_ref;

  // A mismatch sets the flag even in a cycle that writes it to zero,
  // so the clear only holds once the reference has been reloaded.
  assign next_irq_flag = mismatch ? 1'b1 :
                         wr_irq ? reg_wdata[BIT_IRQ_FLAG] :
                         irq_flag;

  assign next_irq_bits = wr_irq ?
    {reg_wdata[BIT_GLOBAL_ENABLE], reg_wdata[BIT_PERIPH_ENABLE],
     reg_wdata[BIT_IRQ_ENABLE]} :
    {global_enable, periph_enable, irq_enable};

  // ==================================================================
  // Writable control.

  assign next_control = wr_cmp ? reg_wdata[5:0] : control;
  assign next_port_data = wr_dat ? reg_wdata[5:0] : port_data;
  assign next_port_dir  = wr_dir ? reg_wdata[5:0] : port_dir;

  // ==================================================================
  // Read data.

  wire [PORT_LINES-1:0] analog_mask = {2'h0, analog_of(mode)};
  wire [PORT_LINES-1:0] port_view   = pin_sync & ~analog_mask;

  wire [7:0] rd_cmp = {result, control};
  wire [7:0] rd_irq = {4'h0, global_enable, periph_enable,
                       irq_enable, irq_flag};
  wire [7:0] rd_dat = {2'h0, port_view};
  wire [7:0] rd_dir = {2'h0, port_dir};

  assign next_rdata = !reg_rd ? 8'h00 :
                      sel_cmp ? rd_cmp :
                      sel_irq ? rd_irq :
                      sel_dat ? rd_dat :
                      sel_dir ? rd_dir : 8'h00;

  // ==================================================================
  // Interrupt request and wake.

  wire all_enabled = irq_enable && periph_enable && global_enable;
  wire next_irq    = irq_flag && all_enabled;
  wire next_wake   = irq_flag && irq_enable && halt;

  // ==================================================================
  // Registers.

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      control <= RST_CONTROL;
    end else if (ce) begin
      control <= next_control;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag      <= RST_IRQ[BIT_IRQ_FLAG];
      irq_enable    <= RST_IRQ[BIT_IRQ_ENABLE];
      periph_enable <= RST_IRQ[BIT_PERIPH_ENABLE];
      global_enable <= RST_IRQ[BIT_GLOBAL_ENABLE];
    end else if (ce) begin
      irq_flag      <= next_irq_flag;
      irq_enable    <= next_irq_bits[0];
      periph_enable <= next_irq_bits[1];
      global_enable <= next_irq_bits[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_data <= RST_PORT_DAT;
      port_dir  <= RST_PORT_DIR;
    end else if (ce) begin
      port_data <= next_port_data;
      port_dir  <= next_port_dir;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      result_ref <= RST_RESULT;
    end else if (ce) begin
      result_ref <= next_result_ref;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      irq_req   <= 1'b0;
      wake_req  <= 1'b0;
    end else if (ce) begin
      reg_rdata <= next_rdata;
      irq_req   <= next_irq;
      wake_req  <= next_wake;
    end
  end

  // ==================================================================
  // Analog side controls.

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmp_mode_sel  <= RST_CONTROL[MODE_MSB:0];
      input_switch  <= 1'b0;
      vref_to_plus  <= 1'b0;
      cmp_power     <= 1'b0;
      analog_select <= '0;
    end else if (ce) begin
      cmp_mode_sel  <= mode;
      input_switch  <= (mode == MODE_INT_REF) && in_switch;
      vref_to_plus  <= (mode == MODE_INT_REF);
      cmp_power     <= active;
      analog_select <= analog_of(mode);
    end
  end

  // ==================================================================
  // Output pins of lines 4 and 5.

  port_a_pin_mux u_pin_mux (
    .route_out  (route_out),
    .cmp_raw    ({cmp2_raw, cmp1_raw}),
    .polarity   (polarity),
    .latch_data (port_data[5:4]),
    .direction  (port_dir[5:4]),
    .pin_out    (port_a_hi_out),
    .pin_oe_b   (port_a_hi_oe_b)
  );

endmodule

// ===== rtl/cmp_ctrl_pkg.sv
// Constants shared by the dual comparator control block.
// Assumes an 8-bit register port with byte-wide data.
package cmp_ctrl_pkg;

  // ==================================================================
  // Register offsets.
  localparam logic [7:0] OFS_CMP_CONTROL = 8'h9c;
  localparam logic [7:0] OFS_IRQ_CONTROL = 8'ha0;
  localparam logic [7:0] OFS_PORT_DATA   = 8'ha1;
  localparam logic [7:0] OFS_PORT_DIR    = 8'ha2;

  // ==================================================================
  // Field positions of comparator_control.
  localparam int BIT_CMP2_RESULT   = 7;
  localparam int BIT_CMP1_RESULT   = 6;
  localparam int BIT_CMP2_POLARITY = 5;
  localparam int BIT_CMP1_POLARITY = 4;
  localparam int BIT_INPUT_SWITCH  = 3;
  localparam int MODE_MSB          = 2;

  // ==================================================================
  // Field positions of irq_control.
  localparam int BIT_IRQ_FLAG      = 0;
  localparam int BIT_IRQ_ENABLE    = 1;
  localparam int BIT_PERIPH_ENABLE = 2;
  localparam int BIT_GLOBAL_ENABLE = 3;

  // ==================================================================
  // Reset values.
  localparam logic [5:0] RST_CONTROL  = 6'h07;
  localparam logic [3:0] RST_IRQ      = 4'h0;
  localparam logic [5:0] RST_PORT_DAT = 6'h00;
  localparam logic [5:0] RST_PORT_DIR = 6'h3f;
  localparam logic [1:0] RST_RESULT   = 2'h0;

  // ==================================================================
  // Mode codes.
  localparam logic [2:0] MODE_RESET   = 3'h0;
  localparam logic [2:0] MODE_OUT_PIN = 3'h3;
  localparam logic [2:0] MODE_INT_REF = 3'h6;
  localparam logic [2:0] MODE_OFF     = 3'h7;

  // ==================================================================
  // Port line widths.
  localparam int PORT_LINES   = 6;
  localparam int ANALOG_LINES = 4;

endpackage

// ===== rtl/sync2.sv
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is a level from outside the clock's domain.
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // ==================================================================
  // One pair of flip-flops per bit.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          meta[i] <= 1'b0;
          q[i]    <= 1'b0;
        end else if (ce) begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// ===== rtl/port_a_pin_mux.sv
// Output path of port lines 4 and 5.
// Assumes raw comparator levels straight from the analog side.
`timescale 1ns/100ps
module port_a_pin_mux (
  input  wire logic       route_out,
  input  wire logic [1:0] cmp_raw,
  input  wire logic [1:0] polarity,
  input  wire logic [1:0] latch_data,
  input  wire logic [1:0] direction,
  output logic      [1:0] pin_out,
  output logic      [1:0] pin_oe_b
);

  // ==================================================================
  // Comparator levels reach the pins with no clocked stage.
  wire [1:0] cmp_level = cmp_raw ^ polarity;

  assign pin_out  = route_out ? cmp_level : latch_data;
  assign pin_oe_b = direction;

endmodule

// ===== verif/dual_comparator_control_checker.sv
// Port checks for the dual comparator control block.
// Assumes one clock domain, clk_sys, and the async low reset rst_b.
`timescale 1ns/100ps
module dual_comparator_control_checker
  import cmp_ctrl_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       cmp1_raw,
  input wire logic       cmp2_raw,
  input wire logic [1:0] port_a_hi_out,
  input wire logic [1:0] port_a_hi_oe_b,
  input wire logic [2:0] cmp_mode_sel,
  input wire logic       input_switch,
  input wire logic       vref_to_plus,
  input wire logic       irq_req
);
  logic [5:0] ctl;
  logic [2:0] en;
  // ==========================================================
  // Shadow of the writable control bits and the three enables.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= RST_CONTROL;
      en  <= 3'h0;
    end else if (ce && reg_wr && reg_addr == OFS_CMP_CONTROL) begin
      ctl <= reg_wdata[5:0];
    end else if (ce && reg_wr && reg_addr == OFS_IRQ_CONTROL) begin
      en <= reg_wdata[3:1];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_reset_off: assert property (!$past(rst_b) |-> cmp_mode_sel == MODE_OFF && !irq_req)
    else $error("bad state after reset");
  a_mode_copy: assert property (cmp_mode_sel == $past(ctl[2:0]))
    else $error("mode differs from written value");
  a_ctrl_read: assert property (ce && reg_rd && reg_addr == OFS_CMP_CONTROL |=> reg_rdata[5:0] == ctl)
    else $error("control read differs");
  a_vref_mode: assert property (vref_to_plus == ($past(ctl[2:0]) == MODE_INT_REF))
    else $error("reference routing wrong");
  a_switch_mode: assert property (input_switch == ($past(ctl[3]) && $past(ctl[2:0]) == MODE_INT_REF))
    else $error("input switch wrong");
  a_pin_direct: assert property (ctl[2:0] == MODE_OUT_PIN |->
    port_a_hi_out == ({cmp2_raw, cmp1_raw} ^ ctl[5:4]))
    else $error("pin output not the comparator level");
  a_dir_gate: assert property (ce && reg_wr && reg_addr == OFS_PORT_DIR |=>
    port_a_hi_oe_b == $past(reg_wdata[5:4]))
    else $error("direction not applied");
  a_irq_gate: assert property (irq_req |-> $past(&en))
    else $error("request without all enables");
  a_change_irq: assert property (($rose(cmp1_raw) || $rose(cmp2_raw)) && &en &&
    cmp_mode_sel != MODE_RESET && cmp_mode_sel != MODE_OFF |-> ##[1:6] irq_req)
    else $error("change raised no request");
  c_irq: cover property ($rose(irq_req));
  c_pin: cover property (cmp_mode_sel == MODE_OUT_PIN && port_a_hi_out != 2'h0);
  c_switch: cover property (input_switch);
endmodule
bind dual_comparator_control dual_comparator_control_checker dual_comparator_control_checker_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp1_raw(cmp1_raw),
  .cmp2_raw(cmp2_raw), .port_a_hi_out(port_a_hi_out), .port_a_hi_oe_b(port_a_hi_oe_b),
  .cmp_mode_sel(cmp_mode_sel), .input_switch(input_switch), .vref_to_plus(vref_to_plus),
  .irq_req(irq_req));

// ===== verif/analog_inputs.sv
// Analog side: comparator decisions and port pin levels.
// Assumes the bench sets the wanted levels; they arrive 7 ns after they are set.
`timescale 1ns/100ps
module analog_inputs (
  input  wire logic [1:0] above,
  input  wire logic [5:0] pins,
  output logic      [1:0] cmp_raw,
  output logic      [5:0] pin_lvl
);
  // High while the plus input exceeds the minus input.
  assign #7 cmp_raw = above;
  assign #7 pin_lvl = pins;
endmodule

// ===== verif/tb.sv
// Register-level bench for the dual comparator control block.
// Assumes the package offsets and the analog_inputs model.
`timescale 1ns/100ps
module tb;
  import cmp_ctrl_pkg::*;
  logic       clk_sys, rst_b, ce, reg_wr, reg_rd, halt, sw, vref, pwr, irq, wake;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] above, hi_out, hi_oe_b, raw;
  logic [5:0] pins, pin_lvl;
  logic [2:0] mode_sel;
  logic [3:0] an_sel;
  int         fail_count, num_checks;
  analog_inputs analog_inputs_inst (.above(above), .pins(pins), .cmp_raw(raw), .pin_lvl(pin_lvl));
  dual_comparator_control dual_comparator_control_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp1_raw(raw[0]),
    .cmp2_raw(raw[1]), .port_a_in(pin_lvl), .port_a_hi_out(hi_out), .port_a_hi_oe_b(hi_oe_b),
    .cmp_mode_sel(mode_sel), .input_switch(sw), .vref_to_plus(vref), .cmp_power(pwr),
    .analog_select(an_sel), .halt(halt), .irq_req(irq), .wake_req(wake));
  // ==========================================================
  // Bus tasks and comparison.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #(50 * 4000);
    fail_count++;
    stop_test();
  end
  // ==========================================================
  // Test sequence.
  initial begin
    {rst_b, reg_wr, reg_rd, halt} = 4'h0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    above = 2'h0;
    pins = 6'h00;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(OFS_CMP_CONTROL, 8'h07);
    rd(OFS_IRQ_CONTROL, 8'h00);
    rd(OFS_PORT_DIR, 8'h3f);
    rd(8'h55, 8'h00);
    wr(OFS_CMP_CONTROL, 8'hcf);
    rd(OFS_CMP_CONTROL, 8'h0f);
    for (int m = 0; m < 8; m++) begin
      wr(OFS_CMP_CONTROL, 8'(m));
      rd(OFS_CMP_CONTROL, 8'(m));
      chk("vref_to_plus", 8'(m == 6), {7'h0, vref});
      chk("cmp_power", 8'(m != 0 && m != 7), {7'h0, pwr});
    end
    wr(OFS_CMP_CONTROL, 8'h0e);
    @(posedge clk_sys);
    #1 chk("input_switch", 8'h01, {7'h0, sw});
    wr(OFS_CMP_CONTROL, 8'h06);
    @(posedge clk_sys);
    #1 chk("input_switch", 8'h00, {7'h0, sw});
    wr(OFS_CMP_CONTROL, 8'h02);
    @(posedge clk_sys) above <= 2'h1;
    repeat (4) @(posedge clk_sys);
    rd(OFS_CMP_CONTROL, 8'h42);
    wr(OFS_CMP_CONTROL, 8'h32);
    rd(OFS_CMP_CONTROL, 8'hb2);
    wr(OFS_IRQ_CONTROL, 8'h0e);
    rd(OFS_IRQ_CONTROL, 8'h0e);
    @(posedge clk_sys) above <= 2'h3;
    repeat (5) @(posedge clk_sys);
    #1 chk("irq_req", 8'h01, {7'h0, irq});
    rd(OFS_IRQ_CONTROL, 8'h0f);
    wr(OFS_IRQ_CONTROL, 8'h0e);
    rd(OFS_IRQ_CONTROL, 8'h0f);
    rd(OFS_CMP_CONTROL, 8'h32);
    wr(OFS_IRQ_CONTROL, 8'h0e);
    rd(OFS_IRQ_CONTROL, 8'h0e);
    wr(OFS_IRQ_CONTROL, 8'h0f);
    rd(OFS_IRQ_CONTROL, 8'h0f);
    wr(OFS_IRQ_CONTROL, 8'h00);
    @(posedge clk_sys) above <= 2'h1;
    repeat (5) @(posedge clk_sys);
    rd(OFS_IRQ_CONTROL, 8'h01);
    chk("irq_req", 8'h00, {7'h0, irq});
    @(posedge clk_sys) halt <= 1'b1;
    wr(OFS_IRQ_CONTROL, 8'h03);
    @(posedge clk_sys);
    #1 chk("wake_req", 8'h01, {7'h0, wake});
    rd(OFS_CMP_CONTROL, 8'hb2);
    wr(OFS_IRQ_CONTROL, 8'h00);
    wr(OFS_PORT_DIR, 8'h00);
    chk("port_a_hi_oe_b", 8'h00, {6'h0, hi_oe_b});
    wr(OFS_CMP_CONTROL, 8'h03);
    @(posedge clk_sys) above <= 2'h2;
    #10 chk("port_a_hi_out", 8'h02, {6'h0, hi_out});
    wr(OFS_PORT_DIR, 8'h3f);
    chk("port_a_hi_oe_b", 8'h03, {6'h0, hi_oe_b});
    @(posedge clk_sys) pins <= 6'h3f;
    repeat (4) @(posedge clk_sys);
    rd(OFS_PORT_DATA, 8'h30);
    wr(OFS_CMP_CONTROL, 8'h07);
    @(posedge clk_sys);
    #1 chk("analog_select", 8'h00, {4'h0, an_sel});
    rd(OFS_PORT_DATA, 8'h3f);
    wr(OFS_CMP_CONTROL, 8'h1a);
    @(posedge clk_sys) rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(OFS_CMP_CONTROL, 8'h07);
    stop_test();
  end
endmodule
